// File: erp_irq_ctrl.sv
// external request sensing, status flags, enables and secondary priority
//
// Overview of operation
// - secondary priority register clears on reset and hardware standby
// - bit 7 sets 8-bit timer channels 0 and 1 to high priority
// - bit 6 sets 8-bit timer channels 2 and 3 to high priority
// - bit 5 sets dma channels 0 and 1 to high priority
// - bits 3, 2, 1 set serial channels 0, 1, 2 to high priority
// - priority bits 4 and 0 are plain storage
// - request status clears on reset and hardware standby
// - status bits 7 and 6 ignore writes and read zero
// - software may only clear status flags, writing zero
// - zero write clears a flag only after it was read as one
// - level mode: flag clears on handling while pin is high
// - edge mode: flag clears on handling
// - level mode: flag sets while pin samples low
// - edge mode: flag sets on a high to low change
// - request enable clears on reset and hardware standby
// - enable bits 5 to 0 gate lines 5 to 0
// - enable bits 7 and 6 are plain storage
// - sense control clears on reset and hardware standby
// - sense bits 5 to 0 pick level (0) or falling edge (1)
// - sense bits 7 and 6 are plain storage
// - lines 0 to 5 carry vector numbers 12 to 17
// - equal level: the smaller vector number wins
// - pins are sensed whatever their port direction
`timescale 1ns/1ps
module erp_irq_ctrl
    import erp_pkg::*;
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rstn_i,
    input  wire logic               hw_standby_i,
    // external request pins, active low
    input  wire logic [N_LINES-1:0] ext_request_pin_n_i,
    // exception handling done, one pulse per line
    input  wire logic [N_LINES-1:0] exc_handled_i,
    // register port
    input  wire logic [ADDR_W-1:0]  addr_i,
    input  wire logic [REG_W-1:0]   wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic      [REG_W-1:0]   rdata_o,
    // requests towards arbitration
    output logic      [N_LINES-1:0] ext_req_o,
    output logic                    ext_vector_valid_o,
    output logic      [VEC_W-1:0]   ext_vector_o,
    // priority levels of internal sources
    output logic                    prio_timer8_ch01_o,
    output logic                    prio_timer8_ch23_o,
    output logic                    prio_dma_ch01_o,
    output logic                    prio_serial_ch0_o,
    output logic                    prio_serial_ch1_o,
    output logic                    prio_serial_ch2_o
);

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    function automatic logic [2:0] lowest_set(
        input logic [N_LINES-1:0] v);
        lowest_set = 3'd0;
        for (int i = N_LINES - 1; i >= 0; i--) begin
            if (v[i]) begin
                lowest_set = 3'(i);
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // pin sampling
    // ---------------------------------------------------------------
    erp_sense_if sns_if ();

    // pins are read straight, no direction gating
    erp_pin_sense u_sense (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .pins_n_i (ext_request_pin_n_i),
        .sns      (sns_if.sense)
    );

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [REG_W-1:0]   sense_control_r;
    logic [REG_W-1:0]   request_enable_r;
    logic [REG_W-1:0]   secondary_priority_r;
    logic [N_LINES-1:0] line_request_flag_r;
    logic [N_LINES-1:0] line_request_flag_nxt;
    logic [N_LINES-1:0] read_armed_r;
    logic [N_LINES-1:0] read_armed_nxt;
    logic [REG_W-1:0]   rdata_r;
    logic [REG_W-1:0]   rdata_nxt;
    logic               vec_valid_r;
    logic [VEC_W-1:0]   vec_r;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    wire logic wr_sense  = wr_i & reg_hit(addr_i, OFS_SENSE_CONTROL);
    wire logic wr_enable = wr_i & reg_hit(addr_i, OFS_REQUEST_ENABLE);
    wire logic wr_status = wr_i & reg_hit(addr_i, OFS_REQUEST_STATUS);
    wire logic wr_prio   = wr_i & reg_hit(addr_i, OFS_SECONDARY_PRIO);
    wire logic rd_sense  = rd_i & reg_hit(addr_i, OFS_SENSE_CONTROL);
    wire logic rd_enable = rd_i & reg_hit(addr_i, OFS_REQUEST_ENABLE);
    wire logic rd_status = rd_i & reg_hit(addr_i, OFS_REQUEST_STATUS);
    wire logic rd_prio   = rd_i & reg_hit(addr_i, OFS_SECONDARY_PRIO);

    // ---------------------------------------------------------------
    // flag set and clear terms
    // ---------------------------------------------------------------
    wire logic [N_LINES-1:0] line_sense_select = sense_control_r[N_LINES-1:0];
    wire logic [N_LINES-1:0] line_enable_bits  = request_enable_r[N_LINES-1:0];

    // level or edge chosen per line
    wire logic [N_LINES-1:0] set_lvl = ~line_sense_select & sns_if.pin_low;
    wire logic [N_LINES-1:0] set_edg = line_sense_select & sns_if.fall_seen;
    wire logic [N_LINES-1:0] flag_set = set_lvl | set_edg;

    // handling clears: level needs pin high edge always
    wire logic [N_LINES-1:0] hw_clr =
        exc_handled_i & (line_sense_select | ~sns_if.pin_low);

    // only a written zero on an armed flag clears it
    wire logic [N_LINES-1:0] sw_clr =
        {N_LINES{wr_status}} & ~wdata_i[N_LINES-1:0] & read_armed_r;

    // a set in the same cycle as a clear wins
    assign line_request_flag_nxt =
        flag_set | (line_request_flag_r & ~hw_clr & ~sw_clr);

    // arming: read while flag is one; dropped when the flag drops
    assign read_armed_nxt =
        ({N_LINES{rd_status}} & line_request_flag_r)
        | (read_armed_r & line_request_flag_nxt);

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    wire logic [REG_W-1:0] status_view =
        {{(REG_W-N_LINES){1'b0}}, line_request_flag_r};

    assign rdata_nxt = rd_sense  ? sense_control_r      :
                       rd_enable ? request_enable_r     :
                       rd_status ? status_view          :
                       rd_prio   ? secondary_priority_r :
                                   8'h00;

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sense_control_r      <= RST_SENSE_CONTROL;
            request_enable_r     <= RST_REQUEST_ENABLE;
            secondary_priority_r <= RST_SECONDARY_PRIO;
        end else if (hw_standby_i) begin
            sense_control_r      <= RST_SENSE_CONTROL;
            request_enable_r     <= RST_REQUEST_ENABLE;
            secondary_priority_r <= RST_SECONDARY_PRIO;
        end else begin
            // all eight bits stored
            if (wr_sense) begin
                sense_control_r <= wdata_i;
            end
            if (wr_enable) begin
                request_enable_r <= wdata_i;
            end
            if (wr_prio) begin
                secondary_priority_r <= wdata_i;
            end
        end
    end

    // ---------------------------------------------------------------
    // status flags and read data
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line_request_flag_r <= RST_REQUEST_STATUS[N_LINES-1:0];
            read_armed_r        <= '0;
            rdata_r             <= 8'h00;
        end else if (hw_standby_i) begin
            line_request_flag_r <= RST_REQUEST_STATUS[N_LINES-1:0];
            read_armed_r        <= '0;
            rdata_r             <= 8'h00;
        end else begin
            line_request_flag_r <= line_request_flag_nxt;
            read_armed_r        <= read_armed_nxt;
            rdata_r             <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

    // ---------------------------------------------------------------
    // requests and vector selection
    // ---------------------------------------------------------------
    // a line asks only with flag and enable set
    assign ext_req_o = line_request_flag_r & line_enable_bits;

    // lowest line index holds the smaller vector
    wire logic [2:0]       win_idx = lowest_set(ext_req_o);
    wire logic [VEC_W-1:0] win_vec = VEC_EXT_BASE + VEC_W'(win_idx);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vec_valid_r <= 1'b0;
            vec_r       <= 8'h00;
        end else begin
            vec_valid_r <= |ext_req_o;
            vec_r       <= win_vec;
        end
    end

    assign ext_vector_valid_o = vec_valid_r;
    assign ext_vector_o       = vec_r;

    // ---------------------------------------------------------------
    // internal source priority levels
    // ---------------------------------------------------------------
    // one level bit per source group
    assign prio_timer8_ch01_o = secondary_priority_r[BIT_PRIO_TIMER8_CH01];
    assign prio_timer8_ch23_o = secondary_priority_r[BIT_PRIO_TIMER8_CH23];
    assign prio_dma_ch01_o    = secondary_priority_r[BIT_PRIO_DMA_CH01];
    assign prio_serial_ch0_o  = secondary_priority_r[BIT_PRIO_SERIAL_CH0];
    assign prio_serial_ch1_o  = secondary_priority_r[BIT_PRIO_SERIAL_CH1];
    assign prio_serial_ch2_o  = secondary_priority_r[BIT_PRIO_SERIAL_CH2];

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    logic [REG_W-1:0] wdata_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdata_q <= 8'h00;
        end else begin
            wdata_q <= wdata_i;
        end
    end

    a_standby_clears:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        hw_standby_i |=> (secondary_priority_r == 8'h00)
                         && (line_request_flag_r == '0)
                         && (request_enable_r == 8'h00)
                         && (sense_control_r == 8'h00))
    else $error("standby did not clear registers");

    a_prio_timer_map:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_prio && !hw_standby_i) |=>
            (prio_timer8_ch01_o == wdata_q[7])
            && (prio_timer8_ch23_o == wdata_q[6]))
    else $error("timer priority does not follow write");

    a_prio_serial_map:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_prio && !hw_standby_i) |=>
            ({prio_dma_ch01_o, prio_serial_ch0_o, prio_serial_ch1_o,
              prio_serial_ch2_o} == {wdata_q[5], wdata_q[3:1]}))
    else $error("dma or serial priority does not follow write");

    a_status_high_zero:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_status |=> (rdata_o[7:6] == 2'b00))
    else $error("status upper bits not zero");

    a_clear_needs_read:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_status && !hw_standby_i && (read_armed_r == '0)
         && (exc_handled_i == '0)) |=>
            ((line_request_flag_r & $past(line_request_flag_r))
             == $past(line_request_flag_r)))
    else $error("unarmed zero write cleared flag");

    a_armed_zero_clears:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_status && !hw_standby_i && read_armed_r[0] && !wdata_i[0]
         && !flag_set[0]) |=> !line_request_flag_r[0])
    else $error("armed zero write kept flag");

    a_one_write_keeps:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (wr_status && !hw_standby_i && (wdata_i[N_LINES-1:0] == '1)
         && (exc_handled_i == '0)) |=>
            ((line_request_flag_r & $past(line_request_flag_r))
             == $past(line_request_flag_r)))
    else $error("written one cleared flag");

    a_level_sets_flag:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!hw_standby_i && !line_sense_select[2] && sns_if.pin_low[2])
            |=> line_request_flag_r[2])
    else $error("low level did not set flag");

    a_edge_sets_flag:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!hw_standby_i && line_sense_select[1] && sns_if.fall_seen[1])
            |=> line_request_flag_r[1])
    else $error("falling edge did not set flag");

    a_edge_ack_clears:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!hw_standby_i && line_sense_select[1] && exc_handled_i[1]
         && !sns_if.fall_seen[1]) |=> !line_request_flag_r[1])
    else $error("handling did not clear edge flag");

    a_disabled_quiet:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (line_enable_bits == '0) |-> (ext_req_o == '0))
    else $error("request while all lines disabled");

    a_vector_lowest:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        ext_req_o[0] |=> ext_vector_valid_o && (ext_vector_o == 8'h0c))
    else $error("line 0 not chosen with vector 12");

    a_valid_follows:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ext_req_o != '0) |=> ext_vector_valid_o)
    else $error("request without vector valid");

    a_valid_drops:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ext_req_o == '0) |=> !ext_vector_valid_o)
    else $error("vector valid without request");

    a_vector_range:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        ext_vector_valid_o |-> (ext_vector_o >= VEC_EXT_BASE)
            && (ext_vector_o < VEC_EXT_BASE + VEC_W'(N_LINES)))
    else $error("vector outside external range");

    a_sync_latency:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        $fell(ext_request_pin_n_i[2]) |-> ##2 sns_if.pin_low[2])
    else $error("pin low not seen two edges later");

    a_rdata_one_cycle:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        !rd_i |=> (rdata_o == 8'h00))
    else $error("read data outside read answer cycle");

endmodule

// File: erp_pkg.sv
// shared constants for the external request sense and priority block
package erp_pkg;

    // ---------------------------------------------------------------
    // geometry
    // ---------------------------------------------------------------
    localparam int unsigned N_LINES = 6;
    localparam int unsigned REG_W   = 8;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned VEC_W   = 8;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_SENSE_CONTROL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_REQUEST_ENABLE = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_REQUEST_STATUS = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_SECONDARY_PRIO = 8'h03;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [REG_W-1:0] RST_SENSE_CONTROL  = 8'h00;
    localparam logic [REG_W-1:0] RST_REQUEST_ENABLE = 8'h00;
    localparam logic [REG_W-1:0] RST_REQUEST_STATUS = 8'h00;
    localparam logic [REG_W-1:0] RST_SECONDARY_PRIO = 8'h00;

    // ---------------------------------------------------------------
    // field positions of the secondary priority register
    // ---------------------------------------------------------------
    localparam int unsigned BIT_PRIO_TIMER8_CH01 = 7;
    localparam int unsigned BIT_PRIO_TIMER8_CH23 = 6;
    localparam int unsigned BIT_PRIO_DMA_CH01    = 5;
    localparam int unsigned BIT_PRIO_SERIAL_CH0  = 3;
    localparam int unsigned BIT_PRIO_SERIAL_CH1  = 2;
    localparam int unsigned BIT_PRIO_SERIAL_CH2  = 1;

    // ---------------------------------------------------------------
    // vector numbering of the external lines
    // ---------------------------------------------------------------
    localparam logic [VEC_W-1:0] VEC_EXT_BASE = 8'h0c;

endpackage

// File: erp_sense_if.sv
// carrier between the pin sampler and the request controller
`timescale 1ns/1ps
interface erp_sense_if;
    import erp_pkg::*;

    logic [N_LINES-1:0] pin_low;
    logic [N_LINES-1:0] fall_seen;

    modport sense (output pin_low, output fall_seen);
    modport ctrl  (input  pin_low, input  fall_seen);
endinterface

// File: erp_pin_sense.sv
// per-pin synchroniser and falling-edge detector
`timescale 1ns/1ps
module erp_pin_sense
    import erp_pkg::*;
(
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rstn_i,
    // request pins, active low
    input  wire logic [N_LINES-1:0] pins_n_i,
    // sampled results
    erp_sense_if.sense              sns
);

    // ---------------------------------------------------------------
    // two-stage synchroniser plus one history stage per pin
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N_LINES; g++) begin : g_line
            logic meta_r;
            logic sync_r;
            logic prev_r;

            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_r <= 1'b1;
                    sync_r <= 1'b1;
                    prev_r <= 1'b1;
                end else begin
                    meta_r <= pins_n_i[g];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                end
            end

            // level taken from the last sample, edge from two successive samples
            assign sns.pin_low[g]   = ~sync_r;
            assign sns.fall_seen[g] = prev_r & ~sync_r;
        end
    endgenerate

endmodule

// File: erp_pin_devices.sv
// behavioural model of the external devices on the request pins
`timescale 1ns/1ps
module erp_pin_devices
    import erp_pkg::*;
(
    // clock of the sampling side
    input  logic               clk_i,
    // request pins, active low
    output logic [N_LINES-1:0] pins_n_o
);
    // ---------------------------------------------------------------
    // idle: every device lets its line sit high
    // ---------------------------------------------------------------
    initial begin
        pins_n_o = '1;
    end

    // ---------------------------------------------------------------
    // line control, moved just after a rising edge
    // ---------------------------------------------------------------
    task automatic pull_low(input int n);
        @(posedge clk_i);
        pins_n_o[n] <= 1'b0;
    endtask

    task automatic let_go(input int n);
        @(posedge clk_i);
        pins_n_o[n] <= 1'b1;
    endtask
endmodule

// File: erp_irq_ctrl_tb_top.sv
// self-checking bench for the external request block
`timescale 1ns/1ps
module erp_irq_ctrl_tb_top;
    import erp_pkg::*;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic               clk_i;
    logic               rstn_i;
    logic               hw_standby_i;
    logic [N_LINES-1:0] pins_n;
    logic [N_LINES-1:0] exc_handled_i;
    logic [ADDR_W-1:0]  addr_i;
    logic [REG_W-1:0]   wdata_i;
    logic               wr_i;
    logic               rd_i;
    logic [REG_W-1:0]   rdata_o;
    logic [N_LINES-1:0] ext_req_o;
    logic               vld_o;
    logic [VEC_W-1:0]   vec_o;
    logic [5:0]         prio_o;
    logic               p_t01, p_t23, p_dma, p_s0, p_s1, p_s2;
    logic [REG_W-1:0]   wv;
    int                 n_mismatch;
    int                 n_checks;
    int                 cycles;

    // ---------------------------------------------------------------
    // design and far side
    // ---------------------------------------------------------------
    erp_irq_ctrl i_dut (
        .clk_i               (clk_i),
        .rstn_i              (rstn_i),
        .hw_standby_i        (hw_standby_i),
        .ext_request_pin_n_i (pins_n),
        .exc_handled_i       (exc_handled_i),
        .addr_i              (addr_i),
        .wdata_i             (wdata_i),
        .wr_i                (wr_i),
        .rd_i                (rd_i),
        .rdata_o             (rdata_o),
        .ext_req_o           (ext_req_o),
        .ext_vector_valid_o  (vld_o),
        .ext_vector_o        (vec_o),
        .prio_timer8_ch01_o  (p_t01),
        .prio_timer8_ch23_o  (p_t23),
        .prio_dma_ch01_o     (p_dma),
        .prio_serial_ch0_o   (p_s0),
        .prio_serial_ch1_o   (p_s1),
        .prio_serial_ch2_o   (p_s2)
    );

    assign prio_o = {p_t01, p_t23, p_dma, p_s0, p_s1, p_s2};

    erp_pin_devices i_dev (
        .clk_i    (clk_i),
        .pins_n_o (pins_n)
    );

    // ---------------------------------------------------------------
    // clock and hang guard
    // ---------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp,
                          input string what);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        check(what, rdata_o, exp);
    endtask

    task automatic handled(input int n);
        @(posedge clk_i);
        exc_handled_i <= 6'h01 << n;
        @(posedge clk_i);
        exc_handled_i <= 6'h00;
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        rstn_i        = 1'b0;
        hw_standby_i  = 1'b0;
        exc_handled_i = 6'h00;
        addr_i        = 8'h00;
        wdata_i       = 8'h00;
        wr_i          = 1'b0;
        rd_i          = 1'b0;
        n_mismatch    = 0;
        n_checks      = 0;
        cycles        = 0;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            reg_rd(a[7:0], 8'h00, "reset value");
        end
        // priority bits, one at a time
        for (int i = 0; i < 8; i++) begin
            wv = 8'h01 << i;
            reg_wr(OFS_SECONDARY_PRIO, wv);
            settle(0);
            check("prio out", {2'b00, prio_o}, {2'b00, wv[7:5], wv[3:1]});
            reg_rd(OFS_SECONDARY_PRIO, wv, "prio readback");
        end
        // spare bits and an unmapped place
        reg_wr(OFS_REQUEST_ENABLE, 8'hc0);
        reg_rd(OFS_REQUEST_ENABLE, 8'hc0, "enable spare");
        reg_wr(OFS_SENSE_CONTROL, 8'hc0);
        reg_rd(OFS_SENSE_CONTROL, 8'hc0, "sense spare");
        reg_wr(8'h04, 8'hff);
        reg_rd(8'h04, 8'h00, "unmapped");
        // level sensing on line 2
        reg_wr(OFS_REQUEST_ENABLE, 8'hff);
        i_dev.pull_low(2);
        settle(5);
        check("req level", {2'b00, ext_req_o}, 8'h04);
        check("vector", vec_o, 8'h0e);
        handled(2);
        reg_rd(OFS_REQUEST_STATUS, 8'h04, "handled low");
        i_dev.let_go(2);
        settle(4);
        handled(2);
        reg_rd(OFS_REQUEST_STATUS, 8'h00, "handled high");
        // falling-edge sensing on every line
        reg_wr(OFS_SENSE_CONTROL, 8'h3f);
        for (int n = 0; n < 6; n++) begin
            i_dev.pull_low(n);
            settle(5);
            check("req edge", {2'b00, ext_req_o}, 8'h01 << n);
            check("vector", vec_o, 8'h0c + n[7:0]);
            handled(n);
            settle(0);
            check("edge handled", {2'b00, ext_req_o}, 8'h00);
            i_dev.let_go(n);
        end
        // two lines at once, read then clear one
        i_dev.pull_low(0);
        i_dev.pull_low(5);
        settle(5);
        check("vector pair", vec_o, 8'h0c);
        check("valid pair", {7'h00, vld_o}, 8'h01);
        reg_wr(OFS_REQUEST_STATUS, 8'h00);
        reg_rd(OFS_REQUEST_STATUS, 8'h21, "unread clear");
        reg_rd(OFS_REQUEST_STATUS, 8'h21, "pair status");
        reg_wr(OFS_REQUEST_STATUS, 8'hff);
        reg_rd(OFS_REQUEST_STATUS, 8'h21, "one write");
        reg_wr(OFS_REQUEST_STATUS, 8'hfe);
        reg_rd(OFS_REQUEST_STATUS, 8'h20, "read clear");
        settle(2);
        check("vector left", vec_o, 8'h11);
        // enable gating
        reg_wr(OFS_REQUEST_ENABLE, 8'h1f);
        settle(2);
        check("req off", {2'b00, ext_req_o}, 8'h00);
        check("valid off", {7'h00, vld_o}, 8'h00);
        reg_wr(OFS_REQUEST_ENABLE, 8'h20);
        settle(0);
        check("req on", {2'b00, ext_req_o}, 8'h20);
        i_dev.let_go(0);
        i_dev.let_go(5);
        // hardware standby clears all four registers
        reg_wr(OFS_SECONDARY_PRIO, 8'hff);
        @(posedge clk_i);
        hw_standby_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        hw_standby_i <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            reg_rd(a[7:0], 8'h00, "standby value");
        end
        check("standby prio", {2'b00, prio_o}, 8'h00);
        check("standby req", {2'b00, ext_req_o}, 8'h00);
        close_out();
    end
endmodule
